// >>> hdl/eewr_host.sv
// Two-wire write host for a small serial EEPROM, with its data FIFO.
module eewr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Filling side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two of at least two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] fill, next_fill;
  logic next_in_ready, next_out_valid, push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_fill = fill + (AW + 1)'(push) - (AW + 1)'(pop);
    next_in_ready = next_fill != (AW + 1)'(DEPTH);
    next_out_valid = next_fill != '0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp <= '0;
      rp <= '0;
      fill <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      fill <= next_fill;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end

  assign out_data = mem[rp];
endmodule

module eewr_host import eewr_pkg::*; #(
  parameter logic [3:0] DEV_TYPE = 4'h6,
  parameter int FIFO_DEPTH = 8,
  parameter int POLL_MAX = 200
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Write command.
  input wire logic cmd_valid,
  input wire eewr_cmd_s cmd,
  output logic cmd_ready,
  // Write data stream.
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic wr_ready,
  // Completion.
  output eewr_stat_s stat,
  output logic busy,
  // Two-wire pins, open drain.
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  if (POLL_MAX < 1 || POLL_MAX >= (1 << TRY_W)) begin : g_chk
    $error("POLL_MAX out of range");
  end
  // DEV_TYPE default is arbitrary; set it to the attached part's type code.

  eewr_state_e st, next_st;
  eewr_step_e step, next_step;
  eewr_cmd_s cmd_q, next_cmd_q;
  eewr_stat_s next_stat;
  logic [PHASE_W-1:0] cnt, next_cnt;
  logic [1:0] ph, next_ph;
  logic [3:0] bit_idx, next_bit_idx;
  logic [7:0] shreg, next_shreg;
  logic [CNT_W-1:0] left, next_left;
  logic [TRY_W-1:0] tries, next_tries;
  logic poll, next_poll, acked, next_acked;
  logic err_n, next_err_n, err_t, next_err_t;
  logic next_scl_oe, next_sda_oe, next_cmd_ready, next_busy;
  logic sda_meta, sda_s, tick, fifo_pop, fifo_valid;
  logic [7:0] fifo_data;

  eewr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(wr_ready),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign tick = cnt == PHASE_W'(PHASE_CYC - 1);

  always_comb begin
    next_st = st;
    next_step = step;
    next_cmd_q = cmd_q;
    next_cnt = tick ? '0 : cnt + 1'b1;
    next_ph = tick ? ph + 1'b1 : ph;
    next_bit_idx = bit_idx;
    next_shreg = shreg;
    next_left = left;
    next_tries = tries;
    next_poll = poll;
    next_acked = acked;
    next_err_n = err_n;
    next_err_t = err_t;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_stat = '0;
    fifo_pop = 1'b0;
    case (st)
      ST_IDLE: begin
        next_cnt = '0;
        next_ph = PH_LOW_A;
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        if (cmd_valid && cmd_ready) begin
          next_cmd_q = cmd;
          next_left = cmd.count;
          next_step = STEP_CTRL;
          next_poll = 1'b0;
          next_err_n = 1'b0;
          next_err_t = 1'b0;
          next_st = ST_START;
        end
      end
      ST_START: begin
        next_scl_oe = 1'b0;
        if (tick && ph == PH_LOW_B) begin
          next_sda_oe = 1'b1;
        end
        if (tick && ph == PH_HIGH_B) begin
          next_scl_oe = 1'b1;
          next_st = ST_LOAD;
        end
      end
      ST_LOAD: begin
        // The clock is held low here, so a slow data source simply stretches the bit.
        next_cnt = '0;
        next_ph = PH_LOW_A;
        next_bit_idx = BIT_FIRST;
        case (step)
          STEP_CTRL: begin
            next_shreg = eewr_ctrl_byte(DEV_TYPE, cmd_q.chip_sel, cmd_q.block_select_bit);
            next_st = ST_BYTE;
          end
          STEP_WADDR: begin
            next_shreg = cmd_q.word_addr;
            next_st = ST_BYTE;
          end
          default: begin
            if (fifo_valid) begin
              fifo_pop = 1'b1;
              next_shreg = fifo_data;
              next_st = ST_BYTE;
            end
          end
        endcase
      end
      ST_BYTE: begin
        next_scl_oe = ph == PH_LOW_A || ph == PH_LOW_B;
        if (tick && ph == PH_LOW_A) begin
          next_sda_oe = bit_idx != BIT_ACK && !shreg[7];
        end
        if (tick && ph == PH_HIGH_A && bit_idx == BIT_ACK) begin
          next_acked = !sda_s;
        end
        if (tick && ph == PH_HIGH_B) begin
          next_scl_oe = 1'b1;
          if (bit_idx != BIT_ACK) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_bit_idx = bit_idx + 1'b1;
          end else begin
            next_st = ST_STOP;
            case (step)
              STEP_CTRL: begin
                if (poll) begin
                  next_tries = tries + 1'b1;
                  if (acked) begin
                    next_poll = 1'b0;
                  end else if (next_tries == TRY_W'(POLL_MAX)) begin
                    next_poll = 1'b0;
                    next_err_t = 1'b1;
                  end
                end else if (acked) begin
                  next_step = STEP_WADDR;
                  next_st = ST_LOAD;
                end else begin
                  next_err_n = 1'b1;
                end
              end
              STEP_WADDR: begin
                if (!acked) begin
                  next_err_n = 1'b1;
                end else if (left != '0) begin
                  next_step = STEP_DATA;
                  next_st = ST_LOAD;
                end
              end
              default: begin
                next_left = left - 1'b1;
                if (!acked) begin
                  next_err_n = 1'b1;
                end else if (left == CNT_W'(1)) begin
                  // The stop that follows launches programming; poll for its end.
                  next_poll = 1'b1;
                  next_tries = '0;
                end else begin
                  next_st = ST_LOAD;
                end
              end
            endcase
          end
        end
      end
      ST_STOP: begin
        next_scl_oe = ph == PH_LOW_A;
        if (tick && ph == PH_LOW_A) begin
          next_sda_oe = 1'b1;
        end
        if (tick && ph == PH_HIGH_A) begin
          next_sda_oe = 1'b0;
        end
        if (tick && ph == PH_HIGH_B) begin
          next_st = ST_FREE;
        end
      end
      ST_FREE: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        if (tick && ph == PH_HIGH_B) begin
          next_step = STEP_CTRL;
          if (poll) begin
            next_st = ST_START;
          end else if (left != '0) begin
            next_st = ST_DRAIN;
          end else begin
            next_stat = '{done: 1'b1, err_nack: err_n, err_timeout: err_t};
            next_st = ST_IDLE;
          end
        end
      end
      ST_DRAIN: begin
        // Bytes of an aborted write are discarded so the next command starts clean.
        next_cnt = '0;
        next_ph = PH_LOW_A;
        if (left == '0) begin
          next_stat = '{done: 1'b1, err_nack: err_n, err_timeout: err_t};
          next_st = ST_IDLE;
        end else if (fifo_valid) begin
          fifo_pop = 1'b1;
          next_left = left - 1'b1;
        end
      end
      default: begin
        next_st = ST_IDLE;
      end
    endcase
    next_cmd_ready = next_st == ST_IDLE;
    next_busy = next_st != ST_IDLE;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= ST_IDLE;
      step <= STEP_CTRL;
      cmd_q <= '0;
      cnt <= '0;
      ph <= PH_LOW_A;
      bit_idx <= BIT_FIRST;
      shreg <= '0;
      left <= '0;
      tries <= '0;
      poll <= 1'b0;
      acked <= 1'b0;
      err_n <= 1'b0;
      err_t <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      stat <= '0;
      cmd_ready <= 1'b0;
      busy <= 1'b0;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      st <= next_st;
      step <= next_step;
      cmd_q <= next_cmd_q;
      cnt <= next_cnt;
      ph <= next_ph;
      bit_idx <= next_bit_idx;
      shreg <= next_shreg;
      left <= next_left;
      tries <= next_tries;
      poll <= next_poll;
      acked <= next_acked;
      err_n <= next_err_n;
      err_t <= next_err_t;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      stat <= next_stat;
      cmd_ready <= next_cmd_ready;
      busy <= next_busy;
      sda_meta <= sda_in;
      sda_s <= sda_meta;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_start_cond: assert property ($rose(sda_oe) && !scl_oe |-> $past(st) == ST_START)
    else $error("SDA pulled low with SCL high outside a start");
  a_stop_cond: assert property ($fell(sda_oe) && !$past(scl_oe) |-> $past(st) == ST_STOP)
    else $error("SDA released with SCL high outside a stop");
  a_data_stable: assert property (!scl_oe && !$past(scl_oe) && st == ST_BYTE |->
      $stable(sda_oe))
    else $error("SDA moved while SCL high during a byte");
  a_high_time: assert property ($fell(scl_oe) |-> !scl_oe [*8])
    else $error("SCL high phase too short");
  a_idle_bus: assert property (st == ST_IDLE && $past(st) == ST_IDLE |-> !scl_oe && !sda_oe)
    else $error("Bus not released while idle");
  a_ack_release: assert property (st == ST_BYTE && bit_idx == BIT_ACK && ph != PH_LOW_A |->
      !sda_oe)
    else $error("Host drives SDA during acknowledge");
  a_ctrl_code: assert property (st == ST_BYTE && step == STEP_CTRL && bit_idx == BIT_FIRST |->
      shreg[7:4] == DEV_TYPE && shreg[0] == DIR_WRITE)
    else $error("Control byte carries wrong type code or direction");
  a_waddr_next: assert property (st == ST_BYTE && step == STEP_CTRL && !poll && tick &&
      ph == PH_HIGH_B && bit_idx == BIT_ACK && acked |=> step == STEP_WADDR && st == ST_LOAD)
    else $error("Word address does not follow acked control byte");
  a_poll_bound: assert property (poll |-> tries < TRY_W'(POLL_MAX))
    else $error("Poll attempts exceed limit");
  a_byte_count: assert property (fifo_pop |-> left != '0)
    else $error("More data bytes taken than commanded");

  c_write_done: cover property (stat.done && !stat.err_nack && !stat.err_timeout);
  c_poll_retry: cover property (poll && st == ST_START && tries != '0);
  c_nack_abort: cover property (stat.done && stat.err_nack);
  c_fifo_full: cover property (!wr_ready && busy);
endmodule

// >>> hdl/eewr_pkg.sv
// Constants, types and helpers shared by the EEPROM write host, the device model and the bench.
package eewr_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_LOW_NS = 4700;
  localparam int T_HIGH_NS = 4000;
  localparam int T_BUF_NS = 4700;
  // One bit lasts four phases; two phases must cover the longer of the low and high times.
  localparam int T_HALF_NS = (T_LOW_NS > T_HIGH_NS) ? T_LOW_NS : T_HIGH_NS;
  localparam int PHASE_CYC = (T_HALF_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int PHASE_W = 8;
  localparam int TRY_W = 8;
  localparam int CNT_W = 4;
  localparam logic [1:0] PH_LOW_A = 2'h0;
  localparam logic [1:0] PH_LOW_B = 2'h1;
  localparam logic [1:0] PH_HIGH_A = 2'h2;
  localparam logic [1:0] PH_HIGH_B = 2'h3;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic DIR_WRITE = 1'h0;

  typedef struct packed {
    logic [1:0] chip_sel;
    logic block_select_bit;
    logic [7:0] word_addr;
    logic [CNT_W-1:0] count;
  } eewr_cmd_s;

  typedef struct packed {
    logic done;
    logic err_nack;
    logic err_timeout;
  } eewr_stat_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_LOAD, ST_BYTE, ST_STOP, ST_FREE, ST_DRAIN
  } eewr_state_e;

  typedef enum logic [1:0] {STEP_CTRL, STEP_WADDR, STEP_DATA} eewr_step_e;

  function automatic logic [7:0] eewr_ctrl_byte(input logic [3:0] dev, input logic [1:0] cs,
                                                input logic blk);
    eewr_ctrl_byte = {dev, cs[1], cs[0], blk, DIR_WRITE};
  endfunction
endpackage

// >>> sim/eewr_dev_model.sv
// Behavioural serial EEPROM that answers the write host on the two wires.
module eewr_dev_model import eewr_pkg::*; #(
  // Device type code; the value is arbitrary and only has to match the host.
  parameter logic [3:0] DEV_TYPE = 4'h6,
  parameter int PROG_NS = 100000
) (
  // Bus wires.
  input wire logic scl,
  input wire logic sda,
  // Hard-wired select pins.
  input wire logic chip_select_low_pin,
  input wire logic chip_select_high_pin,
  // High while the model pulls the data wire low.
  output logic sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [512];
  logic [7:0] page [8];
  logic [7:0] page_vld = 8'h00;
  logic [8:0] ptr = 9'h000;
  logic [7:0] shreg;
  logic blk = 1'b0;
  int phase_st = 0;
  int nbits = 0;
  int nbytes = 0;
  bit acking = 1'b0;
  time busy_until = 0;

  initial sda_pull = 1'b0;

  always @(negedge sda) if (scl === 1'b1) begin
    phase_st = 1;
    nbits = 0;
    acking = 1'b0;
    sda_pull = 1'b0;
  end

  // The array is written at once; only the busy window models the program time.
  always @(posedge sda) if (scl === 1'b1) begin
    if (phase_st == 3 && nbytes > 0) begin
      for (int i = 0; i < 8; i++) if (page_vld[i]) mem[{ptr[8:3], 3'(i)}] = page[i];
      busy_until = $time + nbytes * PROG_NS;
    end
    phase_st = 0;
    nbytes = 0;
    page_vld = 8'h00;
  end

  always @(posedge scl) if (phase_st != 0 && nbits < 8) begin
    shreg = {shreg[6:0], sda};
    nbits++;
  end

  always @(negedge scl) begin
    if (acking) begin
      sda_pull = 1'b0;
      acking = 1'b0;
      nbits = 0;
    end else if (phase_st != 0 && nbits == 8) begin
      acking = phase_st != 1 || (shreg[7:4] == DEV_TYPE && shreg[0] == DIR_WRITE
        && shreg[3:2] == {chip_select_high_pin, chip_select_low_pin}
        && $time >= busy_until);
      if (!acking) phase_st = 0;
      else if (phase_st == 1) blk = shreg[1];
      else if (phase_st == 2) ptr = {blk, shreg};
      else begin
        page[ptr[2:0]] = shreg;
        page_vld[ptr[2:0]] = 1'b1;
        ptr[2:0] = ptr[2:0] + 3'h1;
        if (nbytes < 8) nbytes++;
      end
      if (acking && phase_st < 3) phase_st++;
      sda_pull = acking;
    end
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the EEPROM write host against a behavioural device.
module tb import eewr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic rst_b;
  logic cmd_valid;
  logic wr_valid;
  eewr_cmd_s cmd;
  logic [7:0] wr_data;
  logic cmd_ready, wr_ready, busy, scl_out, scl_oe, sda_out, sda_oe, dev_pull;
  eewr_stat_s stat;
  logic [1:0] pins;
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe || dev_pull);
  int num_errors = 0;
  int checks = 0;
  logic [31:0] seed = 32'h26A3CBB5;
  logic [7:0] q [$];

  eewr_host #(.DEV_TYPE(4'h6), .FIFO_DEPTH(8), .POLL_MAX(3)) uut (.clk(clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .stat(stat), .busy(busy), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  eewr_dev_model #(.DEV_TYPE(4'h6), .PROG_NS(100000)) dev (.scl(scl_w), .sda(sda_w),
    .chip_select_low_pin(pins[0]), .chip_select_high_pin(pins[1]), .sda_pull(dev_pull));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] expv);
    checks++;
    if (seen !== expv) begin
      num_errors++;
      $display("wrong value at %0d ns: saw %h, expected %h", $time, seen, expv);
    end
  endtask

  task automatic give_verdict();
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Offers n random bytes back to back and records them for the later memory checks.
  task automatic push(input int n);
    int i;
    for (int k = 0; k < n; k++) begin
      seed = lfsr(seed);
      wr_data <= seed[7:0];
      wr_valid <= 1'b1;
      q.push_back(seed[7:0]);
      i = 0;
      do begin
        @(posedge clk);
        i++;
      end while (wr_ready !== 1'b1 && i < 50);
      if (wr_ready !== 1'b1) begin
        num_errors++;
        give_verdict();
      end
    end
    wr_valid <= 1'b0;
  endtask

  task automatic run_cmd(input logic [1:0] cs, input logic blk, input logic [7:0] wa,
                         input logic [3:0] cnt, output eewr_stat_s s);
    int i;
    cmd <= '{chip_sel: cs, block_select_bit: blk, word_addr: wa, count: cnt};
    cmd_valid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 50);
    if (cmd_ready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    cmd_valid <= 1'b0;
    @(posedge clk);
    check(9'({busy, cmd_ready, scl_out, sda_out}), 9'h008);
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (stat.done !== 1'b1 && i < 70000);
    if (stat.done !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
    s = stat;
  endtask

  initial begin
    eewr_stat_s s;
    logic [7:0] d;
    rst_b <= 1'b0;
    cmd_valid <= 1'b0;
    wr_valid <= 1'b0;
    cmd <= '0;
    wr_data <= 8'h00;
    pins = 2'b10;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Single byte, acked on a later poll once programming ends.
    push(1);
    run_cmd(2'b10, 1'b0, 8'h3A, 4'h1, s);
    check(9'(s), 9'h004);
    d = q.pop_front();
    check(9'(dev.mem[9'h03A]), 9'(d));
    // Wrong chip bits: refused, queued bytes are still drained.
    push(2);
    run_cmd(2'b01, 1'b0, 8'h3A, 4'h2, s);
    check(9'(s), 9'h006);
    check(9'(dev.mem[9'h03A]), 9'(d));
    check(9'(wr_ready), 9'h001);
    q.delete();
    // Pointer set only, upper block.
    run_cmd(2'b10, 1'b1, 8'hC5, 4'h0, s);
    check(9'(s), 9'h004);
    check(dev.ptr, 9'h1C5);
    // Full page near the block end; programming outlasts the poll limit.
    push(8);
    repeat (3) @(posedge clk);
    check(9'(wr_ready), 9'h000);
    run_cmd(2'b10, 1'b1, 8'hFC, 4'h8, s);
    check(9'(s), 9'h005);
    for (int k = 0; k < 8; k++) check(9'(dev.mem[{6'h3F, 3'(k + 4)}]), 9'(q.pop_front()));
    // New command while the page is still programming.
    run_cmd(2'b10, 1'b0, 8'h00, 4'h0, s);
    check(9'(s), 9'h006);
    check(9'(wr_ready), 9'h001);
    give_verdict();
  end
endmodule
